// ### logic/bha_regs.vh
// timing and field constants for the bus hold arbiter
`ifndef BHA_REGS_VH
`define BHA_REGS_VH
// requester codes
`define BHA_SRC_CPU 2'h0
`define BHA_SRC_DMA 2'h1
`define BHA_SRC_RFSH 2'h2
// idle states inserted on leaving hold
`define BHA_EXIT_IDLES 2'h2
// legacy status value
`define BHA_LEGACY_STATUS 3'h0
`endif

// ### logic/bha_arbiter.v
// bus hold arbitration logic of the local bus interface
`timescale 1ns/1ns
`include "bha_regs.vh"

module bha_arbiter #(
	parameter SEQ_MAX = 3
) (
	input wire clk,
	input wire reset_n,
	input wire clk_en,
	input wire hold_req,
	input wire cpu_req,
	input wire cpu_write,
	input wire cpu_io,
	input wire cpu_odd_word,
	input wire cpu_lock,
	input wire cpu_inta,
	input wire dma_req,
	input wire [1:0] dma_cycles,
	input wire dma_write,
	input wire dma_io,
	input wire refresh_req,
	input wire read_strobe_pin_n,
	input wire [1:0] queue_status,
	output reg proc_clk,
	output reg bus_grant_out,
	output reg cycle_origin_status,
	output wire [2:0] legacy_status_lines,
	output reg io_memory_status,
	output reg [1:0] bus_status,
	output reg bus_lines_oe,
	output reg data_bus_enable,
	output reg data_bus_enable_oe,
	output reg addr_latch_strobe,
	output reg write_strobe_n,
	output reg read_strobe_n,
	output reg cycle_done,
	output reg refresh_done
);

// ****************************************
// sequencer states
// ****************************************
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_T1 = 3'h1;
localparam [2:0] ST_T2 = 3'h2;
localparam [2:0] ST_T3 = 3'h3;
localparam [2:0] ST_T4 = 3'h4;
localparam [2:0] ST_HOLD = 3'h5;
localparam [2:0] ST_EXIT = 3'h6;
localparam [2:0] LEGACY_LEVEL = `BHA_LEGACY_STATUS;

// ****************************************
// clock divider
// ****************************************
// the divider runs without the enable so the output clock keeps its duty
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		proc_clk <= 1'b0;
	end else begin
		proc_clk <= ~proc_clk;
	end
end

// ****************************************
// hold request synchroniser
// ****************************************
reg hold_meta;
reg hold_sync;

// hold comes from another master's clock; only hold_sync is read past here
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		hold_meta <= 1'b0;
		hold_sync <= 1'b0;
	end else if (clk_en) begin
		hold_meta <= hold_req;
		hold_sync <= hold_meta;
	end
end

// ****************************************
// queue status strap
// ****************************************
reg strap_meta;
reg strap_sync;
reg queue_mode;
reg [1:0] strap_wait;

// the strap is read once, after the pin level has passed both flip-flops
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		strap_meta <= 1'b1;
		strap_sync <= 1'b1;
		queue_mode <= 1'b0;
		strap_wait <= 2'h0;
	end else if (clk_en) begin
		strap_meta <= read_strobe_pin_n;
		strap_sync <= strap_meta;
		if (strap_wait != 2'h3) begin
			strap_wait <= strap_wait + 2'h1;
		end
		if (strap_wait == 2'h2) begin
			queue_mode <= ~strap_sync;
		end
	end
end

// ****************************************
// bus sequencer
// ****************************************
reg [2:0] state;
reg [1:0] src;
reg [1:0] seq_left;
reg seq_locked;
reg cur_write;
reg cur_io;
reg [1:0] exit_cnt;
reg refresh_drop;

// a cycle boundary may hand over the bus only when no atomic sequence is open
wire seq_open = (seq_left != 2'h0) || seq_locked;
wire lock_now = cpu_lock || cpu_inta;
wire grant_ok = hold_sync && !seq_open && !lock_now;
wire dma_ok = dma_req && !lock_now;
wire any_req = cpu_req || dma_ok || refresh_req;

// legacy lines are tied one by one so each pin has its own driver
genvar gi;
generate
	for (gi = 0; gi < 3; gi = gi + 1) begin : g_legacy
		assign legacy_status_lines[gi] = LEGACY_LEVEL[gi];
	end
endgenerate

always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		state <= ST_IDLE;
		src <= `BHA_SRC_CPU;
		seq_left <= 2'h0;
		seq_locked <= 1'b0;
		cur_write <= 1'b0;
		cur_io <= 1'b0;
		exit_cnt <= 2'h0;
		refresh_drop <= 1'b0;
		bus_grant_out <= 1'b0;
		cycle_done <= 1'b0;
		refresh_done <= 1'b0;
	end else if (clk_en) begin
		cycle_done <= 1'b0;
		refresh_done <= 1'b0;
		case (state)
		ST_IDLE, ST_T4: begin
			if (state == ST_T4) begin
				cycle_done <= 1'b1;
				refresh_done <= (src == `BHA_SRC_RFSH);
			end
			// hold seen at the boundary wins over waiting internal requests
			if (grant_ok) begin
				state <= ST_HOLD;
				bus_grant_out <= 1'b1;
				refresh_drop <= 1'b0;
			end else if (seq_left != 2'h0) begin
				// continue an open dma, split-word or interrupt acknowledge sequence
				seq_left <= seq_left - 2'h1;
				state <= ST_T1;
			end else if (refresh_req) begin
				src <= `BHA_SRC_RFSH;
				cur_write <= 1'b0;
				cur_io <= 1'b0;
				seq_locked <= 1'b0;
				state <= ST_T1;
			end else if (dma_ok) begin
				src <= `BHA_SRC_DMA;
				cur_write <= dma_write;
				cur_io <= dma_io;
				seq_locked <= 1'b0;
				// dma_cycles holds the count beyond the first, one to three
				seq_left <= (dma_cycles == 2'h0) ? 2'h1 : dma_cycles;
				state <= ST_T1;
			end else if (cpu_req) begin
				// late hold: an already chosen cpu cycle goes ahead
				src <= `BHA_SRC_CPU;
				cur_write <= cpu_write;
				cur_io <= cpu_io;
				seq_locked <= cpu_inta;
				seq_left <= (cpu_odd_word || cpu_inta) ? 2'h1 : 2'h0;
				state <= ST_T1;
			end else begin
				seq_locked <= 1'b0;
				state <= ST_IDLE;
			end
		end
		ST_T1: state <= ST_T2;
		ST_T2: state <= ST_T3;
		ST_T3: state <= ST_T4;
		ST_HOLD: begin
			if (!hold_sync) begin
				bus_grant_out <= 1'b0;
				exit_cnt <= `BHA_EXIT_IDLES;
				state <= ST_EXIT;
			end else if (refresh_req && !refresh_drop) begin
				// grant drops, bus stays with the master until it lets go
				bus_grant_out <= 1'b0;
				refresh_drop <= 1'b1;
			end
		end
		ST_EXIT: begin
			if (exit_cnt != 2'h1) begin
				exit_cnt <= exit_cnt - 2'h1;
			end else if (grant_ok) begin
				// a master asking again while the bus is quiet gets it back
				state <= ST_HOLD;
				bus_grant_out <= 1'b1;
				refresh_drop <= 1'b0;
				exit_cnt <= 2'h0;
			end else if (any_req) begin
				state <= ST_IDLE;
				exit_cnt <= 2'h0;
			end
		end
		default: state <= ST_IDLE;
		endcase
	end
end

// ****************************************
// pin drive and status
// ****************************************
wire in_cycle = (state == ST_T1) || (state == ST_T2) ||
	(state == ST_T3) || (state == ST_T4);
wire strobe_window = (state == ST_T2) || (state == ST_T3);
// status goes active in the last exit idle only when work is pending
wire exit_last = (state == ST_EXIT) && (exit_cnt == 2'h1) && any_req && !grant_ok;
wire floated = (state == ST_HOLD) || ((state == ST_EXIT) && !exit_last);

reg next_lines_oe;
reg next_enable;
reg next_origin;
reg next_io;
reg [1:0] next_status;
reg next_latch;
reg next_write_n;
reg next_read_n;

// ****************************************
// next pin values
// ****************************************
// worked out here and registered below, so every pin but the tied legacy lines leaves a flip-flop
always @* begin
	next_lines_oe = !floated;
	next_enable = in_cycle && (state != ST_T1);
	next_origin = in_cycle && (src == `BHA_SRC_DMA);
	next_io = in_cycle && cur_io;
	next_status = 2'h0;
	if (in_cycle || exit_last) begin
		next_status = {cur_write, ~cur_write};
	end
	next_read_n = !(!cur_write && strobe_window);
	if (queue_mode) begin
		// a strapped part trades its latch and write strobes for queue status
		next_latch = queue_status[0];
		next_write_n = queue_status[1];
	end else begin
		next_latch = (state == ST_T1);
		// early write: strobe opens in T2 with data still settling
		next_write_n = !(cur_write && strobe_window);
	end
end

// ****************************************
// float enables
// ****************************************
// latch strobe keeps its drive in hold, the rest float
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		bus_lines_oe <= 1'b1;
		data_bus_enable_oe <= 1'b1;
	end else if (clk_en) begin
		bus_lines_oe <= next_lines_oe;
		data_bus_enable_oe <= next_lines_oe;
	end
end

// ****************************************
// status lines
// ****************************************
// status stays low outside cycles, except the last exit idle with work pending, so an outside decoder sees no command
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		cycle_origin_status <= 1'b0;
		io_memory_status <= 1'b0;
		bus_status <= 2'h0;
	end else if (clk_en) begin
		cycle_origin_status <= next_origin;
		io_memory_status <= next_io;
		bus_status <= next_status;
	end
end

// ****************************************
// strobes and data enable
// ****************************************
// strobes reset inactive so nothing on the bus sees a command during reset
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		data_bus_enable <= 1'b0;
		addr_latch_strobe <= 1'b0;
		write_strobe_n <= 1'b1;
		read_strobe_n <= 1'b1;
	end else if (clk_en) begin
		data_bus_enable <= next_enable;
		addr_latch_strobe <= next_latch;
		write_strobe_n <= next_write_n;
		read_strobe_n <= next_read_n;
	end
end

endmodule

// ### testbench/bha_monitor.sv
// assertion checker on the bus hold arbiter ports
`timescale 1ns/1ns
module bha_monitor (
	input wire clk,
	input wire reset_n,
	input wire hold_req,
	input wire cpu_lock,
	input wire read_strobe_pin_n,
	input wire proc_clk,
	input wire bus_grant_out,
	input wire [2:0] legacy_status_lines,
	input wire [1:0] bus_status,
	input wire bus_lines_oe,
	input wire addr_latch_strobe,
	input wire data_bus_enable,
	input wire write_strobe_n,
	input wire read_strobe_n,
	input wire cycle_done
);
	// ****
	// properties
	// ****
	default clocking dc @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence bus_cycle;
		addr_latch_strobe ##1 data_bus_enable[*2] ##1 (data_bus_enable && cycle_done);
	endsequence
	legacy_low_a: assert property (legacy_status_lines == 3'h0)
		else $error("legacy status not low");
	clock_half_a: assert property ($past(reset_n) |-> proc_clk != $past(proc_clk))
		else $error("processor clock not halved");
	grant_sync_a: assert property ($rose(bus_grant_out) |-> $past(hold_req, 2))
		else $error("grant without synchronised request");
	grant_drop_a: assert property (bus_grant_out && $fell(hold_req) |-> ##[1:4] !bus_grant_out)
		else $error("grant not dropped");
	hold_float_a: assert property (bus_grant_out && $past(bus_grant_out) |->
		!bus_lines_oe && bus_status == 2'h0)
		else $error("bus driven in hold");
	lock_block_a: assert property ($rose(bus_grant_out) |-> !$past(cpu_lock))
		else $error("grant during lock");
	cycle_shape_a: assert property (read_strobe_pin_n && $rose(addr_latch_strobe) |-> bus_cycle)
		else $error("bus cycle malformed");
	strobe_status_a: assert property (read_strobe_pin_n && !(write_strobe_n && read_strobe_n) |->
		bus_status == {!write_strobe_n, !read_strobe_n})
		else $error("strobe and status disagree");
endmodule
bind bha_arbiter bha_monitor u_bha_monitor (.clk(clk), .reset_n(reset_n),
	.hold_req(hold_req), .cpu_lock(cpu_lock), .read_strobe_pin_n(read_strobe_pin_n),
	.proc_clk(proc_clk),
	.bus_grant_out(bus_grant_out), .legacy_status_lines(legacy_status_lines),
	.bus_status(bus_status), .bus_lines_oe(bus_lines_oe),
	.addr_latch_strobe(addr_latch_strobe), .data_bus_enable(data_bus_enable),
	.write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .cycle_done(cycle_done));

// ### testbench/bha_master.sv
// far-side bus master asking for the bus by hold request
`timescale 1ns/1ns
module bha_master (
	input wire clk,
	input wire reset_n,
	input wire want,
	input wire bus_grant_out,
	output reg hold_req
);
	// ****
	// request logic
	// ****
	reg had;
	reg yield;
	wire lost = had && !bus_grant_out && hold_req;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			had <= 1'b0;
			yield <= 1'b0;
			hold_req <= 1'b0;
		end else begin
			had <= bus_grant_out;
			// stay off until asked afresh, or refresh could starve
			yield <= lost || (yield && want);
			hold_req <= #1 want && !yield && !lost;
		end
	end
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the bus hold arbiter
`timescale 1ns/1ns
module tb_top;
	// ****
	// stimulus and model
	// ****
	localparam integer LAT = 4;
	reg clk = 1'b0;
	reg reset_n = 1'b0;
	reg want, cpu_req, cpu_write, cpu_io, cpu_odd_word, cpu_lock, cpu_inta;
	reg dma_req, dma_write, dma_io, refresh_req;
	reg [1:0] dma_cycles, queue_status;
	reg strap_n = 1'b1;
	wire hold_req, grant, cod, ale, done, rdone, wsn, iom;
	integer error_cnt = 0;
	integer checked = 0;
	integer seed = 32'h8efca01c;
	integer n, k, kind;
	integer exp_q[$];
	always #4 clk = ~clk;
	bha_master u_bha_master (.clk(clk), .reset_n(reset_n), .want(want),
		.bus_grant_out(grant), .hold_req(hold_req));
	bha_arbiter u_bha_arbiter (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
		.hold_req(hold_req), .cpu_req(cpu_req), .cpu_write(cpu_write), .cpu_io(cpu_io),
		.cpu_odd_word(cpu_odd_word), .cpu_lock(cpu_lock), .cpu_inta(cpu_inta),
		.dma_req(dma_req), .dma_cycles(dma_cycles), .dma_write(dma_write), .dma_io(dma_io),
		.refresh_req(refresh_req), .read_strobe_pin_n(strap_n), .queue_status(queue_status),
		.proc_clk(), .bus_grant_out(grant), .cycle_origin_status(cod),
		.legacy_status_lines(), .io_memory_status(iom), .bus_status(), .bus_lines_oe(),
		.data_bus_enable(), .data_bus_enable_oe(), .addr_latch_strobe(ale),
		.write_strobe_n(wsn), .read_strobe_n(), .cycle_done(done), .refresh_done(rdone));
	function logic pick(input integer s);
		pick = (s == 0) ? grant : (s == 1) ? ale : rdone;
	endfunction
	task give_verdict;
		begin
			if (error_cnt == 0 && checked > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task cmp_cnt(input logic [31:0] got, input logic [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("ERROR %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task cmp_bit(input logic got, input logic exp);
		cmp_cnt({31'h0, got}, {31'h0, exp});
	endtask
	// one edge; counts finished cycles so split sequences show up
	task step;
		begin
			@(posedge clk);
			#1;
			n = n + 1;
			if (done === 1'b1)
				k = k + 1;
			if (n > 300) begin
				error_cnt = error_cnt + 1;
				give_verdict;
			end
		end
	endtask
	task wait_sig(input integer s, input logic v);
		begin
			n = 0;
			k = 0;
			while (pick(s) !== v)
				step;
		end
	endtask
	task shuffle;
		begin
			{cpu_write, cpu_io, dma_write, dma_io, queue_status} = 6'($random(seed));
			dma_cycles = 2'(1 + {$random(seed)} % 3);
		end
	endtask
	task run_seq(input integer kd);
		begin
			shuffle;
			exp_q.push_back(kd == 2 ? 1 + dma_cycles : 2);
			cpu_odd_word = (kd == 0);
			cpu_inta = (kd == 1);
			cpu_req = (kd != 2);
			dma_req = (kd == 2);
			wait_sig(1, 1'b1);
			cmp_bit(cod, kd == 2);
			cmp_bit(iom, kd == 2 ? dma_io : cpu_io);
			{cpu_req, cpu_odd_word, cpu_inta, dma_req} = 4'h0;
			want = 1'b1;
			wait_sig(0, 1'b1);
			step;
			cmp_cnt(k, exp_q.pop_front());
			want = 1'b0;
			wait_sig(0, 1'b0);
		end
	endtask
	initial begin
		{want, cpu_req, cpu_odd_word, cpu_lock, cpu_inta, dma_req, refresh_req} = 7'h0;
		shuffle;
		repeat (16) @(posedge clk);
		#1;
		reset_n = 1'b1;
		want = 1'b1;
		wait_sig(0, 1'b1);
		cmp_cnt(n, LAT);
		refresh_req = 1'b1;
		wait_sig(0, 1'b0);
		cmp_bit(hold_req, 1'b1);
		wait_sig(2, 1'b1);
		refresh_req = 1'b0;
		want = 1'b0;
		step;
		want = 1'b1;
		wait_sig(0, 1'b1);
		want = 1'b0;
		wait_sig(0, 1'b0);
		cmp_cnt(n, LAT);
		for (kind = 0; kind < 3; kind = kind + 1)
			run_seq(kind);
		cpu_lock = 1'b1;
		dma_req = 1'b1;
		want = 1'b1;
		wait_sig(0, 1'b0);
		repeat (20) step;
		cmp_bit(grant, 1'b0);
		cmp_cnt(k, 0);
		{cpu_lock, dma_req} = 2'h0;
		wait_sig(0, 1'b1);
		want = 1'b0;
		wait_sig(0, 1'b0);
		reset_n = 1'b0;
		strap_n = 1'b0;
		n = 0;
		repeat (4) step;
		reset_n = 1'b1;
		repeat (4) step;
		queue_status = 2'h2;
		step;
		cmp_bit(ale, 1'b0);
		cmp_bit(wsn, 1'b1);
		queue_status = 2'h1;
		step;
		cmp_bit(ale, 1'b1);
		cmp_bit(wsn, 1'b0);
		give_verdict;
	end
endmodule
